// ---- verification/rx_model.sv ----
// Receiver datapath stand-in answering power-up and wake-up searches
`timescale 1ns/1ps
module rx_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sequencer side
   input wire logic rx_run,
   input wire logic wakeup_search_en,
   input wire logic [2:0] find_at,
   // Answers
   output logic startup_done,
   output logic wakeup_found,
   output logic wakeup_miss
);
   logic [2:0] n_q;
   logic [3:0] age_q;
   logic hit;
   assign hit = 3'(n_q + 3'h1) == find_at;
   // Power-up ends a cycle after enable; a search answers four cycles after its enable rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         startup_done <= 1'b0;
         age_q <= 4'h0;
         n_q <= 3'h0;
         wakeup_found <= 1'b0;
         wakeup_miss <= 1'b0;
      end else begin
         startup_done <= rx_run;
         age_q <= wakeup_search_en ? age_q + {3'h0, age_q != 4'hF} : 4'h0;
         wakeup_found <= age_q == 4'h3 && hit;
         wakeup_miss <= age_q == 4'h3 && !hit;
         if (age_q == 4'h3)
            n_q <= n_q + 3'h1;
         // Count restarts once polling stops, so each case counts from one
         if (!rx_run && !wakeup_search_en)
            n_q <= 3'h0;
      end
   end
endmodule : rx_model

// ---- verification/spoll_ctrl_properties.sv ----
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module spoll_ctrl_properties #(
   parameter logic [23:0] TIMEOUT_CYCLES = 24'h002710
) (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Datapath events and controls
   input wire logic wakeup_found,
   input wire logic frame_start_detected,
   input wire logic wakeup_search_en,
   input wire logic synth_load,
   input wire logic mid_scan_start,
   input wire logic fifo_clear,
   input wire logic run_active
);
   logic [9:0] gap_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence wake_s;
      wakeup_found && wakeup_search_en;
   endsequence
   // Cycles since the last channel load, saturating so it never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= 10'h000;
      end else if (synth_load) begin
         gap_q <= 10'h000;
      end else if (gap_q != 10'h3FF) begin
         gap_q <= gap_q + 10'h001;
      end
   end
   apb_ready_a: assert property (setup_s |=> pready)
      else $error("pready missing after setup");
   misalign_err_a: assert property (setup_s ##0 (paddr[1:0] != 2'h0) |=> pslverr)
      else $error("misaligned access not refused");
   cfg_read_zero_a: assert property (pready && !pwrite && !pslverr &&
      (paddr[9:2] inside {8'h21, 8'h22, 8'h23, 8'h24, 8'h42, 8'h43, 8'h44, 8'h45})
      |-> prdata == 32'h0) else $error("write-only register read back data");
   settle_gap_a: assert property ($rose(wakeup_search_en) |->
      gap_q >= 10'h23A && gap_q <= 10'h244) else $error("settle time wrong");
   wake_to_run_a: assert property (wake_s |-> ##[1:4] run_active)
      else $error("no run after wake-up");
   run_entry_a: assert property ($rose(run_active) |-> $past(wakeup_found) ||
      $past(wakeup_found, 2) || $past(wakeup_found, 3) || $past(wakeup_found, 4))
      else $error("run entered without wake-up");
   search_idle_a: assert property (wakeup_search_en |-> !run_active)
      else $error("search during run");
   mid_start_a: assert property (mid_scan_start |-> run_active &&
      ($past(frame_start_detected) || $past(frame_start_detected, 2)))
      else $error("ID scan started without frame start");
   fifo_clear_a: assert property (fifo_clear |-> ##[0:3] run_active)
      else $error("FIFO cleared outside run");
endmodule : spoll_ctrl_properties

// ---- verification/testbench.sv ----
// Self-checking bench for the self-polling sequencer
`timescale 1ns/1ps
module testbench;
   import spoll_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v, se_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic rx_run, startup_done, wakeup_found, wakeup_miss, sync_ok;
   logic frame_start_detected, mid_found, mid_miss, end_of_message;
   logic demod_fsk, synth_load, wakeup_search_en, mid_scan_start;
   logic fifo_clear, fifo_write_en, run_active, irq;
   logic [2:0] synth_r, find_at;
   logic [1:0] synth_s, cur_mt;
   logic [7:0] chv [6];
   int miscompares = 0, cmp_count = 0, seed = 5, searches = 0, clears = 0, cur_c = 1;
   spoll_ctrl #(.TIMEOUT_CYCLES(24'h000014)) i_dut (.*);
   rx_model i_rx (.*);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction : ba
   // Entered just after an edge; leaves a spare edge so psel is never set twice
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk(32'(pready), 32'h1, "no ready");
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Single-cycle datapath event: 0 frame start, 1 ID found, 2 end of message, 3 ID miss
   task automatic ev(input int k);
      frame_start_detected <= k == 0;
      mid_found <= k == 1;
      end_of_message <= k == 2;
      mid_miss <= k == 3;
      @(posedge pclk);
      frame_start_detected <= 1'b0;
      mid_found <= 1'b0;
      end_of_message <= 1'b0;
      mid_miss <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : ev
   task automatic wait_run(input logic v);
      int n;
      n = 0;
      while (run_active !== v && n < 6000) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(run_active), 32'(v), "run wait");
   endtask : wait_run
   // Poll with c channels per set, wake-up on search f, exit by mode write if d
   task automatic run_case(input logic [1:0] mt, input int c, input int f, input logic d);
      cur_mt = mt;
      cur_c = c;
      apb(1'b1, ba(IDX_MODE_CTRL0), 32'h0);
      for (int i = 0; i < 6; i++) begin
         chv[i] = 8'($random(seed)) & 8'h1F;
         apb(1'b1, ba(IDX_A_CH1 + 8'(i) + (i > 2 ? 8'h1E : 8'h00)), {24'h0, chv[i]});
      end
      apb(1'b1, ba(IDX_A_MOD), {28'h0, 2'(c), mt});
      apb(1'b1, ba(IDX_B_MOD), {28'h0, 2'(c), mt});
      apb(1'b1, ba(IDX_MODE_CTRL1), 32'h8);
      apb(1'b1, ba(IDX_IRQ_MASK), 32'hF);
      searches = 0;
      clears = 0;
      find_at <= 3'(f);
      apb(1'b1, ba(IDX_MODE_CTRL0), {24'h0, 5'h1C, d, 2'h1});
      rx_run <= 1'b1;
      wait_run(1'b1);
      rx_run <= 1'b0;
      chk(searches, f, "search count");
      chk(32'(demod_fsk), 32'(mt == MOD_FSK), "run modulation");
      chk(clears, 1, "entry clear");
      apb(1'b0, ba(IDX_ACT_CHAN), 32'h0);
      chk(rd_v, 32'((f - 1) % c + 1), "found channel");
      sync_ok <= 1'b1;
      repeat (3) @(posedge pclk);
      ev(0);
      chk(32'(fifo_write_en), 32'h1, "FIFO write");
      ev(1);
      ev(2);
      chk(clears, 2, "frame clear");
      apb(1'b0, ba(IDX_IRQ_STATUS), 32'h0);
      chk(rd_v, 32'hF, "status");
      chk(32'(irq), 32'h1, "irq");
      apb(1'b1, ba(IDX_IRQ_STATUS), 32'hF);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0, "irq clear");
      apb(1'b1, ba(IDX_IRQ_MASK), 32'h0);
      ev(0);
      chk(32'(irq), 32'h0, "masked alert");
      chk(32'(run_active), 32'h1, "still in run");
      apb(1'b0, ba(IDX_IRQ_STATUS), 32'h0);
      chk(rd_v, 32'h1, "second frame");
      ev(3);
      chk(32'(fifo_write_en), 32'h0, "ID miss");
      if (d) begin
         apb(1'b1, ba(IDX_MODE_CTRL0), 32'h0);
         repeat (3) @(posedge pclk);
      end else begin
         sync_ok <= 1'b0;
         repeat (40) @(posedge pclk);
      end
      chk(32'(run_active), 32'h0, "run exit");
      sync_ok <= 1'b0;
      apb(1'b1, ba(IDX_IRQ_STATUS), 32'hF);
   endtask : run_case
   // Channel and polling modulation seen at every search start
   always @(posedge pclk) begin
      se_q <= wakeup_search_en;
      if (fifo_clear === 1'b1)
         clears++;
      if (wakeup_search_en === 1'b1 && se_q !== 1'b1) begin
         chk({27'h0, synth_r, synth_s}, {24'h0, chv[(searches / cur_c) * 3 + searches % cur_c]},
            "synth");
         chk(32'(demod_fsk), 32'(cur_mt != MOD_ASK), "poll modulation");
         searches++;
      end
   end
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, rx_run, sync_ok} = 6'h00;
      {frame_start_detected, mid_found, mid_miss, end_of_message} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      find_at = 3'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ba(IDX_A_MOD + 8'(i)), 32'h0);
         chk(rd_v, 32'h0, "set A readback");
         apb(1'b0, ba(IDX_B_MOD + 8'(i)), 32'h0);
         chk(rd_v, 32'h0, "set B readback");
      end
      apb(1'b1, ba(IDX_ACT_CHAN), 32'h3);
      apb(1'b0, ba(IDX_ACT_CHAN), 32'h0);
      chk(rd_v, 32'h0, "found channel reset");
      apb(1'b0, 12'h089, 32'h0);
      chk(32'(err_v), 32'h1, "misaligned");
      apb(1'b0, 12'hC00, 32'h0);
      chk(32'(err_v), 32'h1, "unmapped");
      run_case(MOD_ASK, 1, 2, 1'b1);
      run_case(MOD_FSK, 2, 2, 1'b0);
      run_case(MOD_SWITCH, 3, 3, 1'b0);
      run_case(MOD_SWITCH, 3, 5, 1'b1);
      apb(1'b1, ba(IDX_MODE_CTRL0), 32'h2);
      repeat (4) @(posedge pclk);
      chk({27'h0, synth_r, synth_s}, {24'h0, chv[0]}, "slave channel");
      chk(32'(demod_fsk), 32'h0, "slave modulation");
      give_verdict();
   end
   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      give_verdict();
   end
endmodule : testbench
bind spoll_ctrl spoll_ctrl_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_props (.*);

// ---- verilog/spoll_ctrl.sv ----
// Self-polling channel scan, modulation switch and run-state sequencer
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module spoll_ctrl
   import spoll_pkg::*;
#(
   parameter logic [23:0] TIMEOUT_CYCLES = 24'h002710
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receiver datapath events
   input wire logic rx_run,
   input wire logic startup_done,
   input wire logic wakeup_found,
   input wire logic wakeup_miss,
   input wire logic sync_ok,
   input wire logic frame_start_detected,
   input wire logic mid_found,
   input wire logic mid_miss,
   input wire logic end_of_message,
   // Receiver control
   output logic demod_fsk,
   output logic [2:0] synth_r,
   output logic [1:0] synth_s,
   output logic synth_load,
   output logic wakeup_search_en,
   output logic mid_scan_start,
   output logic fifo_clear,
   output logic fifo_write_en,
   output logic run_active,
   output logic irq
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] mode0_q, mode1_q, a_mod_q, b_mod_q;
   logic [7:0] a_ch_q [3];
   logic [7:0] b_ch_q [3];
   logic [1:0] found_channel_code_q;
   logic [3:0] irq_status_q, irq_mask_q, irq_event;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   ctrl_state_t state_q;
   logic [1:0] chan_q;
   logic cfg_b_q;
   logic [9:0] settle_q;
   logic [23:0] timeout_q;
   logic demod_fsk_q, synth_load_q, search_en_q, mid_start_q;
   logic fifo_clear_q, fifo_wr_q, run_q, irq_q;
   logic [2:0] synth_r_q;
   logic [1:0] synth_s_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic setup_ph, wr_acc;
   logic [7:0] idx;
   logic mapped;
   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;
   assign idx = paddr[9:2];

   // Address map check, misaligned or unknown words are errors
   always_comb begin
      case (idx)
         IDX_MODE_CTRL0, IDX_MODE_CTRL1, IDX_ACT_CHAN, IDX_A_MOD, IDX_A_CH1,
         IDX_A_CH2, IDX_A_CH3, IDX_B_MOD, IDX_B_CH1, IDX_B_CH2, IDX_B_CH3,
         IDX_IRQ_STATUS, IDX_IRQ_MASK: mapped = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
         default: mapped = 1'b0;
      endcase
   end

   // Read mux, write-only registers read as zero
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      case (idx)
         IDX_ACT_CHAN: rd_val = {30'h0, found_channel_code_q};
         IDX_IRQ_STATUS: rd_val = {28'h0, irq_status_q};
         IDX_IRQ_MASK: rd_val = {28'h0, irq_mask_q};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Answer in the access cycle right after setup, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup_ph;
         pslverr_q <= setup_ph & ~mapped;
         if (setup_ph && !pwrite && mapped) begin
            prdata_q <= rd_val;
         end else if (setup_ph) begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // Configuration registers
   // Only the low byte of each word is kept, bits 3:0 for the mask; upper write data is dropped on purpose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode0_q <= RST_MODE_CTRL0;
         mode1_q <= RST_MODE_CTRL1;
         a_mod_q <= RST_MOD;
         b_mod_q <= RST_MOD;
         a_ch_q[0] <= RST_CH1;
         a_ch_q[1] <= RST_CH2;
         a_ch_q[2] <= RST_CH3;
         b_ch_q[0] <= RST_CH1;
         b_ch_q[1] <= RST_CH2;
         b_ch_q[2] <= RST_CH3;
         irq_mask_q <= RST_IRQ_MASK;
      end else if (wr_acc) begin
         case (idx)
            IDX_MODE_CTRL0: mode0_q <= pwdata[7:0];
            IDX_MODE_CTRL1: mode1_q <= pwdata[7:0];
            IDX_A_MOD: a_mod_q <= pwdata[7:0];
            IDX_B_MOD: b_mod_q <= pwdata[7:0];
            IDX_A_CH1: a_ch_q[0] <= pwdata[7:0];
            IDX_A_CH2: a_ch_q[1] <= pwdata[7:0];
            IDX_A_CH3: a_ch_q[2] <= pwdata[7:0];
            IDX_B_CH1: b_ch_q[0] <= pwdata[7:0];
            IDX_B_CH2: b_ch_q[1] <= pwdata[7:0];
            IDX_B_CH3: b_ch_q[2] <= pwdata[7:0];
            IDX_IRQ_MASK: irq_mask_q <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Derived configuration
   // ----------------------------------------------------------------
   logic polling, slave_run, dual_en, to_en, mid_en;
   logic [7:0] cur_mod, cur_ch;
   logic [1:0] channel_count, mt;
   assign polling = mode0_q[BIT_MODE_SEL];
   assign slave_run = ~mode0_q[BIT_MODE_SEL] & mode0_q[BIT_SLAVE_RX];
   assign dual_en = mode0_q[BIT_DUAL_CFG];
   assign to_en = mode0_q[BIT_TIMEOUT_EN];
   assign mid_en = mode0_q[BIT_MID_SCAN_EN];
   assign cur_mod = cfg_b_q ? b_mod_q : a_mod_q;
   assign cur_ch = cfg_b_q ? b_ch_q[chan_q] : a_ch_q[chan_q];
   assign mt = cur_mod[1:0];
   // Code 00b is below the minimum and is taken as one channel
   assign channel_count = (cur_mod[3:2] == 2'h0) ? 2'h1 : cur_mod[3:2];

   // Modulation per phase; the run phases see code 10b as ASK
   logic in_run, fsk_now;
   assign in_run = (state_q == ST_RUN_SYNC) | (state_q == ST_RUN_TSI) |
                   (state_q == ST_RUN_MID) | (state_q == ST_RUN_DATA) | (state_q == ST_SLAVE);
   assign fsk_now = (mt == MOD_FSK) | ((mt == MOD_SWITCH) & ~in_run);

   // ----------------------------------------------------------------
   // Scan and run sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         chan_q <= 2'h0;
         cfg_b_q <= 1'b0;
         settle_q <= 10'h000;
         timeout_q <= 24'h000000;
         found_channel_code_q <= 2'h0;
      end else if (!polling) begin
         // Sleep or slave leaves run at once, slave always uses set A channel 1
         state_q <= slave_run ? ST_SLAVE : ST_IDLE;
         chan_q <= 2'h0;
         cfg_b_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE, ST_SLAVE: begin
               cfg_b_q <= 1'b0;
               if (rx_run) begin
                  state_q <= ST_POWER;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_POWER: if (startup_done) state_q <= ST_INIT_LOOP;
            ST_INIT_LOOP: begin
               chan_q <= 2'h0;
               settle_q <= SETTLE_CYCLES;
               state_q <= ST_SETTLE;
            end
            ST_SETTLE: begin
               settle_q <= settle_q - 10'h001;
               if (settle_q == 10'h000) state_q <= ST_SEARCH;
            end
            ST_SEARCH: begin
               if (wakeup_found) begin
                  state_q <= ST_STORE;
               end else if (wakeup_miss) begin
                  if ((chan_q + 2'h1) == channel_count) begin
                     // Last channel of this set, go on to set B if enabled
                     if (dual_en && !cfg_b_q) begin
                        cfg_b_q <= 1'b1;
                        state_q <= ST_INIT_LOOP;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end else begin
                     chan_q <= chan_q + 2'h1;
                     settle_q <= SETTLE_CYCLES;
                     state_q <= ST_SETTLE;
                  end
               end
            end
            // One cycle here lets the found code and wake flag land before run starts
            ST_STORE: begin
               found_channel_code_q <= chan_q + 2'h1;
               timeout_q <= TIMEOUT_CYCLES;
               state_q <= ST_RUN_SYNC;
            end
            // Timeout counts only while sync is missing, and ends run only when enabled
            ST_RUN_SYNC: begin
               timeout_q <= (timeout_q == 24'h000000) ? timeout_q : timeout_q - 24'h000001;
               if (sync_ok) begin
                  state_q <= ST_RUN_TSI;
               end else if (to_en && timeout_q == 24'h000000) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               // Losing sync from any run phase falls back to the sync wait
               if (!sync_ok) begin
                  timeout_q <= TIMEOUT_CYCLES;
                  state_q <= ST_RUN_SYNC;
               end else begin
                  case (state_q)
                     ST_RUN_TSI: if (frame_start_detected) begin
                        state_q <= mid_en ? ST_RUN_MID : ST_RUN_DATA;
                     end
                     ST_RUN_MID: begin
                        if (mid_found) state_q <= ST_RUN_DATA;
                        else if (mid_miss) state_q <= ST_RUN_TSI;
                     end
                     ST_RUN_DATA: if (end_of_message) state_q <= ST_RUN_TSI;
                     default: state_q <= ST_IDLE;
                  endcase
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receiver control outputs, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         demod_fsk_q <= 1'b0;
         synth_r_q <= 3'h0;
         synth_s_q <= 2'h0;
         synth_load_q <= 1'b0;
         search_en_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         // Follows the state, so the switch lands in the same cycle as run_active rises
         demod_fsk_q <= fsk_now;
         synth_r_q <= cur_ch[4:2];
         synth_s_q <= cur_ch[1:0];
         // A pulse per channel load; a set change loads twice, which is harmless
         synth_load_q <= (state_q == ST_INIT_LOOP) | ((state_q == ST_SEARCH) & wakeup_miss);
         search_en_q <= (state_q == ST_SEARCH) & ~wakeup_found & ~wakeup_miss;
         run_q <= in_run & (state_q != ST_SLAVE);
      end
   end

   // FIFO clear at run entry or frame start, writes from frame start to end of message
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_clear_q <= 1'b0;
         fifo_wr_q <= 1'b0;
         mid_start_q <= 1'b0;
      end else begin
         fifo_clear_q <= ((state_q == ST_STORE) & mode0_q[BIT_CYCLE_FIFO_CLR]) |
                         ((state_q == ST_RUN_TSI) & frame_start_detected & sync_ok &
                          mode1_q[BIT_FS_FIFO_CLR]);
         fifo_wr_q <= ((state_q == ST_RUN_MID) | (state_q == ST_RUN_DATA)) & sync_ok &
                      ~end_of_message & polling;
         mid_start_q <= (state_q == ST_RUN_TSI) & frame_start_detected & sync_ok &
                        mid_en & polling;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   always_comb begin
      irq_event = 4'h0;
      irq_event[IRQ_FRAME] = (state_q == ST_RUN_TSI) & frame_start_detected & sync_ok;
      irq_event[IRQ_MID] = (state_q == ST_RUN_MID) & mid_found & sync_ok;
      irq_event[IRQ_EOM] = (state_q == ST_RUN_DATA) & end_of_message & sync_ok;
      irq_event[IRQ_WAKE] = (state_q == ST_STORE);
   end

   // Sticky status, write one to clear; a new event beats a clear
   // The irq line lags status by one cycle, the price of driving it from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_q <= 4'h0;
         irq_q <= 1'b0;
      end else begin
         if (wr_acc && idx == IDX_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~pwdata[3:0]) | irq_event;
         end else begin
            irq_status_q <= irq_status_q | irq_event;
         end
         irq_q <= |(irq_status_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Output drive
   // ----------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign demod_fsk = demod_fsk_q;
   assign synth_r = synth_r_q;
   assign synth_s = synth_s_q;
   assign synth_load = synth_load_q;
   assign wakeup_search_en = search_en_q;
   assign mid_scan_start = mid_start_q;
   assign fifo_clear = fifo_clear_q;
   assign fifo_write_en = fifo_wr_q;
   assign run_active = run_q;
   assign irq = irq_q;
endmodule : spoll_ctrl

// ---- verilog/spoll_pkg.sv ----
// Constants for the self-polling channel and modulation controller
// ----------------------------------------------------------------
// How it works
// - Modulation code 00b is ASK, 01b is FSK, 10b is FSK while polling and ASK in either run.
// - On a wake-up while polling the demodulator switches to the run-state modulation as run_active rises.
// - Channel count bits 3:2 give one to three polled channels; slave mode uses one channel.
// - Polling scans up to three channels per set, each from that set's synthesizer register.
// - After a wake-up the found channel code reads 01b, 10b or 11b, and 00b before any.
// - Synthesizer registers hold R in bits 4:2 and S in bits 1:0 and read back as zero.
// - Entering run does modulation switch, frame-start wait, FIFO clear and writes, ID scan.
// - Frame start, message-identifier found and end of message raise maskable alerts.
// - Run is left on lost sync plus elapsed timeout, or when the host selects sleep or slave.
// - While in run, further frames are received and stored without a new wake-up.
// - The FIFO is cleared at run entry or at frame start, as configured.
// - After loading a channel the scan waits nine times 64 clock periods before searching.
// - Dual configuration enable in bit 2 scans set A then set B; clear means set A only.
// - Frame-start FIFO clear in bit 3 of the second mode register clears on frame start.
// - Timeout enable in bit 5 returns run to polling after a configured time without sync.
// ----------------------------------------------------------------
package spoll_pkg;
   // ----------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_MODE_CTRL0 = 8'h02;
   localparam logic [7:0] IDX_MODE_CTRL1 = 8'h03;
   localparam logic [7:0] IDX_ACT_CHAN = 8'h06;
   localparam logic [7:0] IDX_A_MOD = 8'h21;
   localparam logic [7:0] IDX_A_CH1 = 8'h22;
   localparam logic [7:0] IDX_A_CH2 = 8'h23;
   localparam logic [7:0] IDX_A_CH3 = 8'h24;
   localparam logic [7:0] IDX_B_MOD = 8'h42;
   localparam logic [7:0] IDX_B_CH1 = 8'h43;
   localparam logic [7:0] IDX_B_CH2 = 8'h44;
   localparam logic [7:0] IDX_B_CH3 = 8'h45;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_MODE_CTRL0 = 8'h40;
   localparam logic [7:0] RST_MODE_CTRL1 = 8'h00;
   localparam logic [7:0] RST_MOD = 8'h04;
   localparam logic [7:0] RST_CH1 = 8'h29;
   localparam logic [7:0] RST_CH2 = 8'h08;
   localparam logic [7:0] RST_CH3 = 8'h0A;
   localparam logic [3:0] RST_IRQ_MASK = 4'h0;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_MODE_SEL = 0;
   localparam int BIT_SLAVE_RX = 1;
   localparam int BIT_DUAL_CFG = 2;
   localparam int BIT_TIMEOUT_EN = 5;
   localparam int BIT_MID_SCAN_EN = 6;
   localparam int BIT_CYCLE_FIFO_CLR = 7;
   localparam int BIT_FS_FIFO_CLR = 3;
   localparam int IRQ_FRAME = 0;
   localparam int IRQ_MID = 1;
   localparam int IRQ_EOM = 2;
   localparam int IRQ_WAKE = 3;
   // ----------------------------------------------------------------
   // Modulation codes and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] MOD_ASK = 2'h0;
   localparam logic [1:0] MOD_FSK = 2'h1;
   localparam logic [1:0] MOD_SWITCH = 2'h2;
   localparam int SETTLE_SYS_PERIODS = 9 * 64;
   localparam logic [9:0] SETTLE_CYCLES = 10'(SETTLE_SYS_PERIODS - 1);
   typedef enum logic [3:0] {
      ST_IDLE, ST_POWER, ST_INIT_LOOP, ST_SETTLE, ST_SEARCH, ST_STORE,
      ST_RUN_SYNC, ST_RUN_TSI, ST_RUN_MID, ST_RUN_DATA, ST_SLAVE
   } ctrl_state_t;
endpackage : spoll_pkg
